//--- verilog/codec_pkg.sv
package codec_pkg;
	localparam int WORD_BITS = 64;
	localparam int IDX_W = 6;
	localparam logic [5:0] IDX_TOP = 6'h3F;
	localparam logic [5:0] IDX_LAST = 6'h00;
	// Control mode word layout
	localparam int BIT_MIC_SKIP = 60;
	localparam int BIT_LEVEL = 59;
	localparam int BIT_HANDSHAKE = 58;
	localparam int BIT_AUTOCAL = 56;
	localparam int BIT_CLK_XTAL = 42;
	localparam int BIT_CLK_SRC_HI = 41;
	localparam int BIT_CLK_SRC_LO = 40;
	localparam int BIT_DIV_HI = 39;
	localparam int BIT_DIV_LO = 36;
	localparam int BIT_LOOP_EN = 33;
	localparam int BIT_ANALOG_LOOP = 32;
	// Status byte fixed pattern, bits 63..61 and 57
	localparam logic [2:0] STATUS_TOP = 3'h1;
	localparam logic STATUS_B57 = 1'b0;
	// Data mode word fields
	localparam int BIT_LINE0_ON = 15;
	localparam int BIT_LINE1_ON = 14;
	localparam int BIT_SPK_ON = 13;
	localparam logic [63:0] CTRL_DEFAULT = 64'h0;
	localparam logic [7:0] CAL_FRAMES = 8'hC2;
	localparam logic [1:0] ECHO_VALID_FRAME = 2'h3;
	// Echo line is 127 bits: one bit short of two frames, to undo the
	// one strobe lag of the tx pin, so each echo lands in its own slot
	localparam logic [6:0] ECHO_LAST = 7'h7E;
	localparam logic [1:0] SRC_XTAL = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [1:0] SRC_EXT_DIV = 2'h2;
	localparam logic [1:0] SRC_BITCLK = 2'h3;
	typedef enum logic [2:0] {
		MODE_CTRL = 3'b001,
		MODE_CAL  = 3'b010,
		MODE_DATA = 3'b100
	} mode_t;
endpackage

//--- verilog/word_stream_if.sv
`timescale 1ns/1ns
interface word_stream_if #(parameter int W = 64);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

//--- verilog/echo_mem.sv
`timescale 1ns/1ns
module echo_mem #(
	parameter int AW = 7
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic          wdata,
	output logic               rdata
);
	logic [(1<<AW)-1:0] mem;

	// Read before write: the old bit written 127 strobes back comes out
	always_ff @(posedge clk) begin
		rdata <= mem[addr];
		if (we) begin
			mem[addr] <= wdata;
		end
	end
endmodule

//--- verilog/word_buffer.sv
`timescale 1ns/1ns
module word_buffer #(
	parameter int W = 64
) (
	input  wire logic   clk,
	input  wire logic   rst,
	word_stream_if.sink   in_s,
	word_stream_if.source out_s
);
	typedef struct packed {
		logic [1:0]   count;
		logic [W-1:0] head;
		logic [W-1:0] tail;
	} buf_t;
	buf_t s;
	buf_t next_s;
	logic pop;
	logic push;

	assign in_s.ready = (s.count != 2'h2);
	assign out_s.valid = (s.count != 2'h0);
	assign out_s.data = s.head;
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		next_s = s;
		if (pop) begin
			next_s.head = s.tail;
		end
		if (push) begin
			if (s.count == 2'h0 || (s.count == 2'h1 && pop)) begin
				next_s.head = in_s.data;
			end else begin
				next_s.tail = in_s.data;
			end
		end
		next_s.count = s.count + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	a_buf_no_over: assert property (@(posedge clk) disable iff (rst)
		s.count == 2'h2 && !pop |=> s.count == 2'h2)
		else $error("buffer lost a word while full");
endmodule

//--- verilog/codec_loop_ctrl.sv
// Summary of operation
// - Monitor mix stays usable outside analog loopback and calibration.
// - Extra loopback modes run only when word bit 33 is one.
// - Analog loop feeds outputs to the input stages, external inputs cut.
// - Analog loop disables the monitor mix; outputs stay attenuable.
// - In analog loop, muting line 0 also mutes the looped signal.
// - Digital loop echoes received bits two frames later, valid third frame.
// - Digital loop keeps the DACs converting received data.
// - Master clock picked from crystal, ext clock, divided ext, bit clock; for divided ext it gets ext clock undivided.
// - Two crystal inputs with a selecting multiplexer.
// - Crystal clock is divided to give the sample rate family.
// - A 256xFs clock output is driven from any source.
// - Control from serial words in control mode, fields in data mode.
// - Control settings are sent back on the serial output in control mode; digital loop sends echoes instead.
// - Control words are 64 bits, eight bytes, MSB first.
// - Reset or power down restores defaults; data-only bits reload too.
// - Status byte 63..56 reads 0,0,1,MB,OUTPUT_LEVEL_SELECT,DCB,0,AC; bit 63 sends back stored ctrl bit 63 instead.
// - Mic gain skip bit steers mics around the 20 dB block.
// - Handshake bit coordinates mode changes between the parties.
// - Control to data always runs a 194 frame calibration, mix off.
// - Calibration flags progress, drives zeros on the serial output unless digital loop sends echoes, ignores DAC data.
`timescale 1ns/1ns
module codec_loop_ctrl #(
	parameter int WORD_W = codec_pkg::WORD_BITS
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              power_down,
	input  wire logic              data_mode_req,
	input  wire logic              bit_strobe,
	input  wire logic              frame_sync,
	input  wire logic              serial_rx_pin,
	output logic                   serial_tx_pin,
	input  wire logic              crystal1_in,
	input  wire logic              crystal2_in,
	input  wire logic              ext_clock_in,
	input  wire logic              serial_bit_clock,
	output logic                   master_clock,
	output logic                   clock_256fs_out,
	output logic                   monitor_mix_enable,
	output logic                   analog_loop_active,
	output logic                   ext_inputs_connect,
	output logic                   loop_feedback_mute,
	output logic                   digital_loop_active,
	output logic                   echo_valid,
	output logic                   dac_accept,
	output logic                   calibration_in_progress,
	output logic                   mic_gain_skip,
	output logic                   output_level_select,
	output logic                   mode_handshake_bit,
	output logic                   autocal_request,
	output logic                   line0_unmute,
	output logic                   line1_unmute,
	output logic                   speaker_unmute,
	output logic [WORD_W-1:0]      rx_word,
	output logic                   rx_word_valid,
	input  wire logic              rx_word_ready,
	output logic                   rx_room
);
	initial begin
		if (WORD_W != codec_pkg::WORD_BITS) begin
			$error("codec_loop_ctrl serves 64 bit words only");
		end
	end

	typedef struct packed {
		codec_pkg::mode_t mode;
		logic [5:0]       idx;
		logic [63:0]      shreg;
		logic [63:0]      ctrl;
		logic             line0;
		logic             line1;
		logic             spk;
		logic [7:0]       cal_cnt;
		logic [1:0]       echo_cnt;
		logic [6:0]       ptr;
		logic             strobe_d;
		logic             tx;
		logic             push;
		logic [63:0]      push_word;
		logic             src_d;
		logic [3:0]       div_cnt;
		logic             mclk;
		logic             clk_out;
	} state_t;

	state_t s;
	state_t next_s;
	logic   src;
	logic   xtal;
	logic   echo_bit;
	logic   loop_en;
	logic   word_end;
	logic   status_now;
	logic [7:0] status_byte;

	word_stream_if #(.W(WORD_W)) buf_in ();
	word_stream_if #(.W(WORD_W)) buf_out ();

	assign loop_en = s.ctrl[codec_pkg::BIT_LOOP_EN];
	assign analog_loop_active = loop_en
		&& s.ctrl[codec_pkg::BIT_ANALOG_LOOP];
	assign digital_loop_active = loop_en
		&& !s.ctrl[codec_pkg::BIT_ANALOG_LOOP];
	assign ext_inputs_connect = !analog_loop_active;
	assign monitor_mix_enable = !analog_loop_active
		&& s.mode != codec_pkg::MODE_CAL;
	assign loop_feedback_mute = analog_loop_active && !s.line0;
	assign calibration_in_progress = (s.mode == codec_pkg::MODE_CAL);
	// DACs keep running in digital loop; only calibration blocks them
	assign dac_accept = !calibration_in_progress;
	assign echo_valid = digital_loop_active
		&& s.echo_cnt == codec_pkg::ECHO_VALID_FRAME;
	assign mic_gain_skip = s.ctrl[codec_pkg::BIT_MIC_SKIP];
	assign output_level_select = s.ctrl[codec_pkg::BIT_LEVEL];
	assign mode_handshake_bit = s.ctrl[codec_pkg::BIT_HANDSHAKE];
	assign autocal_request = s.ctrl[codec_pkg::BIT_AUTOCAL];
	assign line0_unmute = s.line0;
	assign line1_unmute = s.line1;
	assign speaker_unmute = s.spk;
	assign serial_tx_pin = s.tx;
	assign master_clock = s.mclk;
	assign clock_256fs_out = s.clk_out;
	assign word_end = bit_strobe && s.idx == codec_pkg::IDX_LAST;
	assign status_byte = {codec_pkg::STATUS_TOP, mic_gain_skip,
		output_level_select, mode_handshake_bit, codec_pkg::STATUS_B57,
		autocal_request};
	assign status_now = status_byte[s.idx[2:0]];

	// Crystal pair mux, then the four-way source select
	assign xtal = s.ctrl[codec_pkg::BIT_CLK_XTAL] ? crystal2_in
		: crystal1_in;
	always_comb begin
		unique case (s.ctrl[codec_pkg::BIT_CLK_SRC_HI:codec_pkg::BIT_CLK_SRC_LO])
			codec_pkg::SRC_XTAL:    src = xtal;
			codec_pkg::SRC_EXT:     src = ext_clock_in;
			codec_pkg::SRC_EXT_DIV: src = ext_clock_in;
			codec_pkg::SRC_BITCLK:  src = serial_bit_clock;
		endcase
	end

	echo_mem #(.AW(codec_pkg::IDX_W + 1)) u_echo (
		.clk   (clk),
		.we    (bit_strobe && digital_loop_active),
		.addr  (s.ptr),
		.wdata (serial_rx_pin),
		.rdata (echo_bit)
	);

	assign buf_in.valid = s.push;
	assign buf_in.data = s.push_word;
	assign rx_room = buf_in.ready;
	assign rx_word = buf_out.data;
	assign rx_word_valid = buf_out.valid;
	assign buf_out.ready = rx_word_ready;

	word_buffer #(.W(WORD_W)) u_buf (
		.clk   (clk),
		.rst   (rst),
		.in_s  (buf_in.sink),
		.out_s (buf_out.source)
	);

	always_comb begin
		logic [63:0] word;
		logic        divided;
		word = {s.shreg[62:0], serial_rx_pin};
		divided = 1'b0;
		next_s = s;
		next_s.push = 1'b0;
		next_s.strobe_d = bit_strobe;
		// A cut frame misplaces the echo for the two frames after it
		if (bit_strobe) begin
			next_s.ptr = (s.ptr == codec_pkg::ECHO_LAST) ? 7'h00
				: s.ptr + 7'h01;
		end
		if (frame_sync && bit_strobe) begin
			next_s.idx = codec_pkg::IDX_TOP - 6'h01;
			next_s.shreg = {63'h0, serial_rx_pin};
			if (digital_loop_active
				&& s.echo_cnt != codec_pkg::ECHO_VALID_FRAME) begin
				next_s.echo_cnt = s.echo_cnt + 2'h1;
			end
		end else if (bit_strobe) begin
			next_s.idx = s.idx - 6'h01;
			next_s.shreg = word;
		end
		if (!digital_loop_active) begin
			next_s.echo_cnt = 2'h0;
		end
		if (word_end) begin
			if (s.mode == codec_pkg::MODE_CTRL) begin
				next_s.ctrl = word;
			end else if (s.mode == codec_pkg::MODE_DATA) begin
				next_s.line0 = word[codec_pkg::BIT_LINE0_ON];
				next_s.line1 = word[codec_pkg::BIT_LINE1_ON];
				next_s.spk = word[codec_pkg::BIT_SPK_ON];
				next_s.push = 1'b1;
				next_s.push_word = word;
			end
		end
		// Tx bit follows the strobe by one cycle, memory read latency
		if (s.strobe_d) begin
			if (digital_loop_active) begin
				next_s.tx = echo_valid && echo_bit;
			end else if (s.mode == codec_pkg::MODE_CTRL) begin
				next_s.tx = s.idx[5:3] == 3'h7 && s.idx != codec_pkg::IDX_TOP
					? status_now : s.ctrl[s.idx];
			end else begin
				next_s.tx = 1'b0;
			end
		end
		unique case (s.mode)
			codec_pkg::MODE_CTRL: begin
				if (data_mode_req) begin
					next_s.mode = codec_pkg::MODE_CAL;
					next_s.cal_cnt = codec_pkg::CAL_FRAMES;
				end
			end
			codec_pkg::MODE_CAL: begin
				// Whole frames counted, so no word begun here is pushed
				if (word_end) begin
					next_s.cal_cnt = s.cal_cnt - 8'h01;
					if (s.cal_cnt == 8'h01) begin
						next_s.mode = codec_pkg::MODE_DATA;
					end
				end
			end
			codec_pkg::MODE_DATA: begin
				if (!data_mode_req) begin
					next_s.mode = codec_pkg::MODE_CTRL;
					next_s.line0 = 1'b0;
					next_s.line1 = 1'b0;
					next_s.spk = 1'b0;
				end
			end
			default: next_s.mode = codec_pkg::MODE_CTRL;
		endcase
		// Clock path: divide crystal or divided ext, pass the others
		next_s.src_d = src;
		next_s.mclk = src;
		if (s.ctrl[codec_pkg::BIT_CLK_SRC_HI:codec_pkg::BIT_CLK_SRC_LO]
			== codec_pkg::SRC_XTAL
			|| s.ctrl[codec_pkg::BIT_CLK_SRC_HI:codec_pkg::BIT_CLK_SRC_LO]
			== codec_pkg::SRC_EXT_DIV) begin
			divided = 1'b1;
		end
		if (!divided) begin
			next_s.clk_out = src;
		end else if (src && !s.src_d) begin
			if (s.div_cnt >= s.ctrl[codec_pkg::BIT_DIV_HI:codec_pkg::BIT_DIV_LO])
				begin
				next_s.div_cnt = 4'h0;
				next_s.clk_out = !s.clk_out;
			end else begin
				next_s.div_cnt = s.div_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || power_down) begin
			s <= '0;
			s.mode <= codec_pkg::MODE_CTRL;
			s.ctrl <= codec_pkg::CTRL_DEFAULT;
			s.idx <= codec_pkg::IDX_TOP;
		end else begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || power_down);

	sequence cal_enter;
		s.mode == codec_pkg::MODE_CTRL && data_mode_req;
	endsequence
	sequence word_tick;
		word_end;
	endsequence

	a_cal_entry: assert property (cal_enter |=>
		calibration_in_progress && s.cal_cnt == codec_pkg::CAL_FRAMES)
		else $error("calibration did not start on mode change");
	a_cal_last: assert property (calibration_in_progress
		&& s.cal_cnt == 8'h01 ##0 word_tick |=> s.mode == codec_pkg::MODE_DATA)
		else $error("calibration did not end after its frames");
	a_cal_dac_block: assert property (calibration_in_progress
		|-> !dac_accept && !monitor_mix_enable && !s.push)
		else $error("data passed during calibration");
	a_analog_loop: assert property (analog_loop_active
		|-> !ext_inputs_connect && !monitor_mix_enable)
		else $error("analog loop left inputs or mix on");
	a_line0_mute: assert property (analog_loop_active && !line0_unmute
		|-> loop_feedback_mute)
		else $error("looped signal not muted with line 0");
	a_loop_gate: assert property (!loop_en
		|-> !analog_loop_active && !digital_loop_active)
		else $error("loopback active without enable");
	a_echo_start: assert property (!digital_loop_active ##1
		digital_loop_active |-> !echo_valid)
		else $error("echo valid too early");
	a_ctrl_latch: assert property (word_end && s.mode
		== codec_pkg::MODE_CTRL |=> s.ctrl == (($past(s.shreg) << 1)
		| 64'($past(serial_rx_pin))))
		else $error("control word not stored");
	a_readback: assert property (s.strobe_d && s.mode
		== codec_pkg::MODE_CTRL && !digital_loop_active
		&& s.idx == 6'(codec_pkg::BIT_MIC_SKIP)
		|=> serial_tx_pin == $past(mic_gain_skip))
		else $error("status bit not returned");
	a_ctrl_defaults: assert property (s.mode == codec_pkg::MODE_DATA
		&& !data_mode_req |=> !line0_unmute && !line1_unmute
		&& !speaker_unmute)
		else $error("data only bits not reloaded");
endmodule

//--- testbench/host_port_model.sv
`timescale 1ns/1ns
module host_port_model (
	input  wire logic clk,
	output logic      bit_strobe,
	output logic      frame_sync,
	output logic      serial_rx_pin,
	input  wire logic serial_tx_pin
);
	initial begin
		bit_strobe = 1'b0;
		frame_sync = 1'b0;
		serial_rx_pin = 1'b0;
	end
	// One word each frame, MSB first; four cycles per bit keeps the gap legal
	task automatic xfer(input logic [63:0] w, output logic [63:0] r);
		for (int i = 63; i >= 0; i--) begin
			@(negedge clk);
			r[i] = serial_tx_pin;
			bit_strobe = 1'b1;
			frame_sync = (i == 63);
			serial_rx_pin = w[i];
			@(negedge clk);
			bit_strobe = 1'b0;
			frame_sync = 1'b0;
			// Bit no longer qualified, so the line shows junk
			serial_rx_pin = ~w[i];
			repeat (2) @(negedge clk);
		end
	endtask
endmodule

//--- testbench/codec_loopback_and_control_mode_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module codec_loopback_and_control_mode_tb_top;
	logic        clk, rst, power_down, data_mode_req, rx_word_ready;
	logic        bit_strobe, frame_sync, serial_rx_pin, serial_tx_pin;
	logic [3:0]  src_in;
	logic        master_clock, mon, aloop, ext_in, fb_mute, dloop, echo_v;
	logic        dac_acc, cal, mgs, ols, hsb, acr, l0, l1, spk, rx_v, rx_room;
	logic [63:0] rx_word, rd, rd2;
	logic        c256;
	int          error_cnt, tests_run, n;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	host_port_model u_host_port_model (.clk(clk), .bit_strobe(bit_strobe),
		.frame_sync(frame_sync), .serial_rx_pin(serial_rx_pin),
		.serial_tx_pin(serial_tx_pin));

	codec_loop_ctrl u_codec_loop_ctrl (.clk(clk), .rst(rst),
		.power_down(power_down), .data_mode_req(data_mode_req),
		.bit_strobe(bit_strobe), .frame_sync(frame_sync),
		.serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
		.crystal1_in(src_in[0]), .crystal2_in(src_in[1]),
		.ext_clock_in(src_in[2]), .serial_bit_clock(src_in[3]),
		.master_clock(master_clock), .clock_256fs_out(c256),
		.monitor_mix_enable(mon), .analog_loop_active(aloop),
		.ext_inputs_connect(ext_in), .loop_feedback_mute(fb_mute),
		.digital_loop_active(dloop), .echo_valid(echo_v),
		.dac_accept(dac_acc), .calibration_in_progress(cal),
		.mic_gain_skip(mgs), .output_level_select(ols),
		.mode_handshake_bit(hsb), .autocal_request(acr),
		.line0_unmute(l0), .line1_unmute(l1), .speaker_unmute(spk),
		.rx_word(rx_word), .rx_word_valid(rx_v),
		.rx_word_ready(rx_word_ready), .rx_room(rx_room));

	task automatic wr(input logic [63:0] w);
		u_host_port_model.xfer(w, rd);
	endtask

	task automatic summarize();
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic t_defaults();
		`CHK({mon, ext_in, dac_acc, aloop, dloop, cal}, 6'h38)
		`CHK({mgs, ols, hsb, acr, l0, l1, spk}, 7'h00)
	endtask

	task automatic t_readback();
		wr(64'h1D00_0000_0000_A5A5);
		`CHK({mgs, ols, hsb, acr}, 4'hF)
		wr(64'h1D00_0000_0000_A5A5);
		`CHK(rd, 64'h3D00_0000_0000_A5A5)
	endtask

	task automatic t_analog();
		wr(64'h0000_0003_0000_0000);
		`CHK({aloop, mon, ext_in, fb_mute, dloop}, 5'h12)
		wr(64'h0000_0001_0000_0000);
		`CHK({aloop, mon, ext_in, dloop}, 4'h6)
	endtask

	task automatic t_digital();
		wr(64'h0000_0002_0000_0000);
		`CHK({dloop, aloop, dac_acc, mon}, 4'hB)
		wr(64'h1500_0002_C3A5_5A3C);
		wr(64'h0A00_0002_0F0F_F0F0);
		u_host_port_model.xfer(64'h1900_0002_DEAD_BEEF, rd2);
		`CHK(rd2, 64'h1500_0002_C3A5_5A3C)
		`CHK(echo_v, 1'b1)
		wr(64'h0000_0000_0000_0000);
		`CHK(rd, 64'h0A00_0002_0F0F_F0F0)
	endtask

	task automatic t_clocks();
		logic [63:0] sel [4];
		logic        c0;
		sel = '{64'h0, 64'h0000_0400_0000_0000, 64'h0000_0100_0000_0000,
			64'h0000_0300_0000_0000};
		for (int k = 0; k < 4; k++) begin
			src_in = 4'h0;
			wr(sel[k]);
			c0 = c256;
			src_in = 4'h1 << k;
			repeat (3) @(negedge clk);
			`CHK(master_clock, 1'b1)
			`CHK(c256, k < 2 ? ~c0 : 1'b1)
			src_in = ~(4'h1 << k);
			repeat (3) @(negedge clk);
			`CHK(master_clock, 1'b0)
			`CHK(c256, k < 2 ? ~c0 : 1'b0)
		end
		// Divided ext clock, divider 1: output toggles every second rise
		src_in = 4'h0;
		wr(64'h0000_0210_0000_0000);
		c0 = c256;
		for (int p = 0; p < 2; p++) begin
			src_in = 4'h4;
			repeat (2) @(negedge clk);
			src_in = 4'h0;
			repeat (2) @(negedge clk);
			`CHK(c256, p == 0 ? c0 : ~c0)
		end
	endtask

	task automatic t_cal_data();
		// Outputs already muted: line bits are cleared in control mode
		data_mode_req = 1'b1;
		repeat (2) @(negedge clk);
		`CHK({cal, mon, dac_acc}, 3'h4)
		n = 0;
		while (cal === 1'b1 && n < 300) begin
			wr(64'h0);
			n++;
		end
		`CHK(n, 194)
		if (n == 300)
			summarize();
		`CHK(rx_v, 1'b0)
		wr(64'hCAFE_0000_0000_E000);
		`CHK({l0, l1, spk, rx_v}, 4'hF)
		`CHK(rx_word, 64'hCAFE_0000_0000_E000)
		wr(64'h0123_4567_89AB_E000);
		`CHK(rx_room, 1'b0)
		wr(64'h7777_0000_0000_E000);
		rx_word_ready = 1'b1;
		@(negedge clk);
		rx_word_ready = 1'b0;
		`CHK(rx_word, 64'h0123_4567_89AB_E000)
		rx_word_ready = 1'b1;
		@(negedge clk);
		rx_word_ready = 1'b0;
		`CHK(rx_v, 1'b0)
		data_mode_req = 1'b0;
		repeat (3) @(negedge clk);
		`CHK({l0, l1, spk, cal}, 4'h0)
	endtask

	task automatic t_power_down();
		wr(64'h1000_0000_0000_0000);
		`CHK(mgs, 1'b1)
		power_down = 1'b1;
		@(negedge clk);
		power_down = 1'b0;
		@(negedge clk);
		`CHK({mgs, mon}, 2'h1)
	endtask

	initial begin
		error_cnt = 0;
		tests_run = 0;
		rst = 1'b1;
		power_down = 1'b0;
		data_mode_req = 1'b0;
		rx_word_ready = 1'b0;
		src_in = 4'h0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_defaults();
		t_readback();
		t_analog();
		t_digital();
		t_clocks();
		t_cal_data();
		t_power_down();
		summarize();
	end
endmodule
